// File: pkg/ppw_pkg.sv
// Package: constants and types for the PROM writer controller
package ppw_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // Pulse timing in microseconds as printed (0.95 ms .. 1.05 ms, 2.85 ms .. 78.75 ms)
  localparam int unsigned T_PULSE_US = 1000;
  localparam int unsigned T_PULSE_MIN_US = 950;
  localparam int unsigned T_OVER_MAX_US = 78750;
  localparam int unsigned T_SETUP_US = 2;
  localparam int unsigned T_OE_NS = 150;
  localparam int unsigned T_FLOAT_NS = 130;
  localparam int unsigned PULSE_CYC = T_PULSE_US * CLK_MHZ;
  localparam int unsigned SETUP_CYC = T_SETUP_US * CLK_MHZ;
  localparam int unsigned OE_CYC = (T_OE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FLOAT_CYC = (T_FLOAT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OVER_FACTOR = 3;
  localparam int unsigned MAX_PULSES = 25;
  localparam logic [14:0] ADDR_START_16K = 15'h4000;
  localparam logic [14:0] ADDR_START_32K = 15'h0000;
  localparam logic [14:0] ADDR_LAST = 15'h7fff;

  typedef enum {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_VSETUP, ST_VREAD, ST_OVER, ST_NEXT,
    ST_FSETUP, ST_FREAD, ST_DONE, ST_FAIL
  } ppw_state_t;
endpackage

// File: pkg/ppw_if.sv
// Interface: timer request and completion between controller and pulse timer
`timescale 1ns/1ps
`default_nettype none
interface ppw_tmr_if;
  logic start;
  logic [31:0] cycles;
  logic done;
  modport ctrl (output start, output cycles, input done);
  modport tmr (input start, input cycles, output done);
endinterface
`default_nettype wire

// File: verilog/ppw_timer.sv
// Module: down-counting interval timer for strobe widths and setup waits
`timescale 1ns/1ps
`default_nettype none
module ppw_timer
  import ppw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timer requests
  ppw_tmr_if.tmr t
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } ppw_tmr_st_t;

  ppw_tmr_st_t s_r;
  ppw_tmr_st_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (t.start)
    begin
      s_nxt.cnt = (t.cycles == 32'h0) ? 32'h1 : t.cycles;
      s_nxt.busy = 1'b1;
    end
    else if (s_r.busy)
    begin
      s_nxt.cnt = s_r.cnt - 32'h1;
      if (s_r.cnt == 32'h1)
      begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign t.done = s_r.done;
endmodule
`default_nettype wire

// File: verilog/ppw_writer.sv
// Module: external PROM writer running the fast programming loop
//
// Function
// (RULE_01) Hold device reset low for programming
// (RULE_02) Drive address, data, strobes, supply pins
// (RULE_03) No ID readback; size given by input
// (RULE_04) Program only 4000-7FFF or 0000-7FFF
// (RULE_05) Both strobes low reads stored byte
// (RULE_06) Data floats when either strobe high
// (RULE_07) Gate high, supply raised, select low writes
// (RULE_08) Verify: select high, gate low
// (RULE_09) Start at core 6V, program 12.5V
// (RULE_10) 1ms pulses until verify, count N
// (RULE_11) Over-program pulse of 3N ms
// (RULE_12) Increment address until last done
// (RULE_13) Final readback at both supplies 5V
// (RULE_14) Initial strobe 0.95 to 1.05 ms
// (RULE_15) Over strobe 2.85 to 78.75 ms
// (RULE_16) Keep oscillator input clocked
// (RULE_17) Abort after 25 failed pulses
// (RULE_18) Device latches address/data at select fall
// (RULE_19) Tie address high bit 7 high
`timescale 1ns/1ps
`default_nettype none
module ppw_writer
  import ppw_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned OSC_DIV = 16
)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Job control
  input wire logic START,
  input wire logic SIZE_32K,
  // Image source
  output logic [14:0] IMG_ADDR,
  input wire logic [7:0] IMG_DATA,
  // Device pins
  output logic DEV_RESET_N,
  output logic OSC_INPUT,
  output logic [7:0] ADDRESS_LOW_PORT,
  output logic [7:0] ADDRESS_HIGH_PORT,
  input wire logic [7:0] DATA_PORT_IN,
  output logic [7:0] DATA_PORT_OUT,
  output logic DATA_PORT_OE,
  output logic CHIP_SELECT_N,
  output logic OUTPUT_GATE_N,
  output logic CORE_SUPPLY_6V,
  output logic PROGRAM_SUPPLY_HI,
  // Status
  output logic BUSY,
  output logic DONE,
  output logic FAIL,
  output logic [14:0] FAIL_ADDR
);
  if (PULSE_CYCLES < 1 || OSC_DIV < 2 || OSC_DIV > 131072 ||
    64'(PULSE_CYCLES) * OVER_FACTOR * MAX_PULSES > 64'hffffffff)
  begin
    $error("ppw_writer: bad parameter");
  end

  localparam logic [31:0] PULSE_W = 32'(PULSE_CYCLES);
  localparam logic [31:0] SETUP_W = 32'(SETUP_CYC);
  localparam logic [31:0] OE_W = 32'(OE_CYC + 2);
  localparam logic [31:0] FLOAT_W = 32'(FLOAT_CYC + 1);
  localparam logic [4:0] MAXP = 5'(MAX_PULSES);

  typedef struct packed {
    ppw_state_t st;
    logic [14:0] addr;
    logic [4:0] n;
    logic [7:0] wdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [15:0] osc_cnt;
    logic osc;
    logic rst_n;
    logic cs_n;
    logic oe_n;
    logic d_oe;
    logic vcc6;
    logic vpp;
    logic busy;
    logic done;
    logic fail;
    logic [14:0] fail_addr;
    logic tstart;
    logic [31:0] tcyc;
  } ppw_st_t;

  ppw_st_t s_r;
  ppw_st_t s_nxt;
  ppw_tmr_if tif ();

  ppw_timer u_timer (
    .clk(REF_CLK),
    .rst(RST),
    .t(tif.tmr)
  );

  assign tif.start = s_r.tstart;
  assign tif.cycles = s_r.tcyc;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tstart = 1'b0;
    // Data pins cross in from the device: two flops
    s_nxt.sync1 = DATA_PORT_IN;
    s_nxt.sync2 = s_r.sync1;
    // Free-running oscillator input for the device
    if (s_r.osc_cnt == 16'(OSC_DIV / 2 - 1)) // RULE_16
    begin
      s_nxt.osc_cnt = 16'h0;
      s_nxt.osc = ~s_r.osc;
    end
    else
      s_nxt.osc_cnt = s_r.osc_cnt + 16'h1;
    case (s_r.st)
      ST_IDLE:
      begin
        if (START)
        begin
          // Range picked from the job, never probed from the part
          s_nxt.addr = SIZE_32K ? ADDR_START_32K : ADDR_START_16K; // RULE_03 RULE_04
          s_nxt.rst_n = 1'b0; // RULE_01
          s_nxt.vcc6 = 1'b1; // RULE_09
          s_nxt.vpp = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
          s_nxt.fail = 1'b0;
          s_nxt.n = 5'h0;
          s_nxt.cs_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = SETUP_W;
          s_nxt.st = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // Gate high, data driven, setup before the strobe falls
        s_nxt.oe_n = 1'b1; // RULE_07
        s_nxt.d_oe = 1'b1;
        s_nxt.wdata = IMG_DATA;
        if (tif.done)
        begin
          s_nxt.cs_n = 1'b0; // RULE_07 RULE_18
          s_nxt.n = s_r.n + 5'h1; // RULE_10
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = PULSE_W; // RULE_14
          s_nxt.st = ST_PULSE;
        end
      end
      ST_PULSE:
      begin
        if (tif.done)
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = SETUP_W;
          s_nxt.st = ST_VSETUP;
        end
      end
      ST_VSETUP:
      begin
        // Release data so the device may drive in verify
        s_nxt.d_oe = 1'b0; // RULE_06
        if (tif.done)
        begin
          s_nxt.oe_n = 1'b0; // RULE_08
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = OE_W;
          s_nxt.st = ST_VREAD;
        end
      end
      ST_VREAD:
      begin
        if (tif.done)
        begin
          s_nxt.oe_n = 1'b1;
          s_nxt.tstart = 1'b1;
          if (s_r.sync2 == s_r.wdata) // RULE_08 RULE_10
          begin
            s_nxt.tcyc = SETUP_W;
            s_nxt.st = ST_OVER;
          end
          else if (s_r.n >= MAXP) // RULE_17
          begin
            s_nxt.fail = 1'b1;
            s_nxt.fail_addr = s_r.addr;
            s_nxt.st = ST_FAIL;
          end
          else
          begin
            s_nxt.tcyc = FLOAT_W + SETUP_W;
            s_nxt.st = ST_SETUP; // RULE_10
          end
        end
      end
      ST_OVER:
      begin
        // Setup wait, then one strobe of 3N pulse widths
        if (s_r.cs_n)
        begin
          s_nxt.d_oe = 1'b1;
          if (tif.done)
          begin
            s_nxt.cs_n = 1'b0;
            s_nxt.tstart = 1'b1;
            s_nxt.tcyc = 32'(PULSE_CYCLES * OVER_FACTOR) * 32'(s_r.n); // RULE_11 RULE_15
          end
        end
        else if (tif.done)
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = SETUP_W;
          s_nxt.st = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        if (tif.done)
        begin
          s_nxt.n = 5'h0;
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = SETUP_W;
          if (s_r.addr == ADDR_LAST) // RULE_12
          begin
            s_nxt.addr = SIZE_32K ? ADDR_START_32K : ADDR_START_16K;
            s_nxt.vcc6 = 1'b0; // RULE_13
            s_nxt.vpp = 1'b0;
            s_nxt.d_oe = 1'b0;
            s_nxt.st = ST_FSETUP;
          end
          else
          begin
            s_nxt.addr = s_r.addr + 15'h1; // RULE_12
            s_nxt.st = ST_SETUP;
          end
        end
      end
      ST_FSETUP:
      begin
        if (tif.done)
        begin
          // Read cycle at 5V: both strobes low
          s_nxt.cs_n = 1'b0; // RULE_05 RULE_13
          s_nxt.oe_n = 1'b0;
          s_nxt.tstart = 1'b1;
          s_nxt.tcyc = OE_W;
          s_nxt.st = ST_FREAD;
        end
      end
      ST_FREAD:
      begin
        if (tif.done)
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.oe_n = 1'b1;
          if (s_r.sync2 != IMG_DATA) // RULE_13
          begin
            s_nxt.fail = 1'b1;
            s_nxt.fail_addr = s_r.addr;
            s_nxt.st = ST_FAIL;
          end
          else if (s_r.addr == ADDR_LAST)
            s_nxt.st = ST_DONE;
          else
          begin
            s_nxt.addr = s_r.addr + 15'h1;
            s_nxt.tstart = 1'b1;
            s_nxt.tcyc = FLOAT_W;
            s_nxt.st = ST_FSETUP;
          end
        end
      end
      ST_DONE, ST_FAIL:
      begin
        s_nxt.vcc6 = 1'b0;
        s_nxt.vpp = 1'b0;
        s_nxt.d_oe = 1'b0;
        s_nxt.cs_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.rst_n = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.done = (s_r.st == ST_DONE);
        s_nxt.st = ST_IDLE;
      end
      default:
        s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.rst_n <= 1'b1;
      s_r.cs_n <= 1'b1;
      s_r.oe_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from state flops
  always_comb
  begin
    IMG_ADDR = s_r.addr;
    DEV_RESET_N = s_r.rst_n;
    OSC_INPUT = s_r.osc;
    ADDRESS_LOW_PORT = s_r.addr[7:0]; // RULE_02
    ADDRESS_HIGH_PORT = {1'b1, s_r.addr[14:8]}; // RULE_19
    DATA_PORT_OUT = s_r.wdata;
    DATA_PORT_OE = s_r.d_oe;
    CHIP_SELECT_N = s_r.cs_n;
    OUTPUT_GATE_N = s_r.oe_n;
    CORE_SUPPLY_6V = s_r.vcc6;
    PROGRAM_SUPPLY_HI = s_r.vpp;
    BUSY = s_r.busy;
    DONE = s_r.done;
    FAIL = s_r.fail;
    FAIL_ADDR = s_r.fail_addr;
  end
endmodule
`default_nettype wire

// File: bench/ppw_checker.sv
// Checker: port properties of the PROM writer
`timescale 1ns/1ps
`default_nettype none
module ppw_checker #(parameter int unsigned PULSE_CYCLES = 20)
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Pins and status
  input wire logic BUSY,
  input wire logic FAIL,
  input wire logic DEV_RESET_N,
  input wire logic OSC_INPUT,
  input wire logic [7:0] ADDRESS_LOW_PORT,
  input wire logic [7:0] ADDRESS_HIGH_PORT,
  input wire logic [7:0] DATA_PORT_OUT,
  input wire logic DATA_PORT_OE,
  input wire logic CHIP_SELECT_N,
  input wire logic OUTPUT_GATE_N,
  input wire logic CORE_SUPPLY_6V,
  input wire logic PROGRAM_SUPPLY_HI
);
  // Cycles the select strobe has been low
  logic [31:0] low_r;
  always_ff @(posedge REF_CLK)
    low_r <= (RST || CHIP_SELECT_N) ? 32'h0 : low_r + 32'h1;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  chk_reset_idle: assert property (disable iff (1'b0) RST |=>
    CHIP_SELECT_N && DEV_RESET_N && !DATA_PORT_OE && !PROGRAM_SUPPLY_HI && !BUSY) else $error("reset state");
  chk_high_bit: assert property (ADDRESS_HIGH_PORT[7]) else $error("address bit 7 low");
  chk_no_fight: assert property (!OUTPUT_GATE_N |-> !DATA_PORT_OE) else $error("data contention");
  chk_write_mode: assert property (!CHIP_SELECT_N && OUTPUT_GATE_N |->
    PROGRAM_SUPPLY_HI && CORE_SUPPLY_6V && DATA_PORT_OE) else $error("write conditions");
  chk_strobe_hold: assert property (!CHIP_SELECT_N && !$past(CHIP_SELECT_N) |->
    $stable(ADDRESS_LOW_PORT) && $stable(ADDRESS_HIGH_PORT) && $stable(DATA_PORT_OUT)) else $error("strobe data moved");
  chk_pulse_len: assert property ($rose(CHIP_SELECT_N) && PROGRAM_SUPPLY_HI |->
    low_r * 20 >= PULSE_CYCLES * 19 && low_r * 20 <= PULSE_CYCLES * 1575) else $error("strobe width");
  chk_osc_runs: assert property (1 |-> ##[1:16] $changed(OSC_INPUT)) else $error("clock stopped");
  chk_fail_idle: assert property ($rose(FAIL) |-> BUSY ##1 !BUSY) else $error("fail flag");
  cover property ($rose(FAIL));
  cover property ($rose(CHIP_SELECT_N) && low_r > PULSE_CYCLES);
  cover property (!OUTPUT_GATE_N && CHIP_SELECT_N && PROGRAM_SUPPLY_HI);
  cover property (!OUTPUT_GATE_N && !CHIP_SELECT_N && !PROGRAM_SUPPLY_HI);
endmodule
bind ppw_writer ppw_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.REF_CLK, .RST, .BUSY, .FAIL, .DEV_RESET_N,
  .OSC_INPUT, .ADDRESS_LOW_PORT, .ADDRESS_HIGH_PORT, .DATA_PORT_OUT, .DATA_PORT_OE, .CHIP_SELECT_N,
  .OUTPUT_GATE_N, .CORE_SUPPLY_6V, .PROGRAM_SUPPLY_HI);
`default_nettype wire

// File: bench/ppw_dev_model.sv
// Model: PROM device in programming mode
`timescale 1ns/1ps
`default_nettype none
module ppw_dev_model
(
  // Device pins
  input wire logic reset_n,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] addr_hi,
  input wire logic [7:0] data_in,
  input wire logic cs_n,
  input wire logic oe_n,
  input wire logic vpp_hi,
  // Cells that never take a write
  input wire logic stuck,
  output logic [7:0] data_out,
  output logic drive
);
  logic [7:0] mem [0:32767];
  logic [14:0] a_q;
  int hits;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
    hits = 0;
  end
  // Cell needs address mod 3 plus one strobes
  always @(negedge cs_n)
  begin
    if (!reset_n && oe_n && vpp_hi)
    begin
      if (a_q != {addr_hi[6:0], addr_lo})
        hits = 0;
      a_q = {addr_hi[6:0], addr_lo};
      hits++;
      if (!stuck && hits > a_q % 3)
        mem[a_q] = data_in;
    end
  end
  assign drive = !reset_n && !oe_n && (!cs_n || vpp_hi);
  assign data_out = mem[{addr_hi[6:0], addr_lo}];
endmodule
`default_nettype wire

// File: bench/ppw_writer_test.sv
// Testbench: writer against the device model
`timescale 1ns/1ps
`default_nettype none
module ppw_writer_test
  import ppw_pkg::*;
;
  localparam int unsigned PC = 20;
  // Registered timer start and load stretch every timed strobe by two cycles
  localparam int unsigned STROBE_LAT = 2;
  typedef struct {logic [14:0] a; logic [7:0] d; int n;} ppw_note_t;
  ppw_note_t q[$];
  logic REF_CLK = 0, RST = 1, START = 0, SIZE_32K = 0, stuck = 0, fail_q = 0, drive;
  logic [7:0] IMG_DATA = 0, key = 0, flt = 0, dev_out, ADDRESS_LOW_PORT, ADDRESS_HIGH_PORT, DATA_PORT_OUT;
  logic [14:0] IMG_ADDR, FAIL_ADDR;
  logic DEV_RESET_N, OSC_INPUT, DATA_PORT_OE, CHIP_SELECT_N, OUTPUT_GATE_N, CORE_SUPPLY_6V;
  logic PROGRAM_SUPPLY_HI, BUSY, DONE, FAIL;
  int err_count = 0, num_checks = 0, lowc = 0, npul = 0;
  wire logic [7:0] DATA_PORT_IN = drive ? dev_out : DATA_PORT_OE ? DATA_PORT_OUT : flt;
  ppw_writer #(.PULSE_CYCLES(PC)) uut (.REF_CLK, .RST, .START, .SIZE_32K, .IMG_ADDR, .IMG_DATA, .DEV_RESET_N,
    .OSC_INPUT, .ADDRESS_LOW_PORT, .ADDRESS_HIGH_PORT, .DATA_PORT_IN, .DATA_PORT_OUT, .DATA_PORT_OE,
    .CHIP_SELECT_N, .OUTPUT_GATE_N, .CORE_SUPPLY_6V, .PROGRAM_SUPPLY_HI, .BUSY, .DONE, .FAIL, .FAIL_ADDR);
  ppw_dev_model dev (.reset_n(DEV_RESET_N), .addr_lo(ADDRESS_LOW_PORT), .addr_hi(ADDRESS_HIGH_PORT),
    .data_in(DATA_PORT_IN), .cs_n(CHIP_SELECT_N), .oe_n(OUTPUT_GATE_N), .vpp_hi(PROGRAM_SUPPLY_HI),
    .stuck(stuck), .data_out(dev_out), .drive(drive));
  initial
  begin
    forever
      #2 REF_CLK = ~REF_CLK;
  end
  function automatic logic [7:0] img(logic [14:0] a);
    return (a[7:0] ^ key) & 8'h7f;
  endfunction
  // Image source and a floating bus that never holds its last value
  always @(negedge REF_CLK)
  begin
    IMG_DATA <= img(IMG_ADDR);
    flt <= ~DATA_PORT_IN;
  end
  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (exp !== got)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic take(int w);
    ppw_note_t e;
    check("note queue", 1, q.size() != 0);
    if (q.size() == 0)
      return;
    e = q.pop_front();
    if (w == 0)
    begin
      check("fail address", e.a, FAIL_ADDR);
      check("failed pulses", e.n, npul);
      return;
    end
    check("address", e.a, {ADDRESS_HIGH_PORT[6:0], ADDRESS_LOW_PORT});
    check("image address", e.a, IMG_ADDR);
    check("data", e.d, DATA_PORT_OUT);
    check("pulses", e.n, npul);
    check("over width", OVER_FACTOR * e.n * PC + STROBE_LAT, w);
  endtask
  // Monitor: one note per over pulse or failure
  always @(negedge REF_CLK)
  begin
    if (RST)
    begin
      lowc = 0;
      npul = 0;
    end
    else if (!CHIP_SELECT_N && OUTPUT_GATE_N)
      lowc++;
    else if (lowc != 0)
    begin
      if (lowc == PC + STROBE_LAT)
        npul++;
      else
      begin
        take(lowc);
        npul = 0;
      end
      lowc = 0;
    end
    if (FAIL && !fail_q)
      take(0);
    fail_q = FAIL;
  end
  task automatic job(logic big, int nb);
    logic [14:0] a;
    int t;
    key = 8'($urandom);
    for (int i = 0; i < nb; i++)
    begin
      a = (big ? ADDR_START_32K : ADDR_START_16K) + i;
      q.push_back('{a, img(a), stuck ? MAX_PULSES : a % 3 + 1});
    end
    SIZE_32K = big;
    START = 1;
    @(negedge REF_CLK);
    check("busy", 1, BUSY);
    check("device reset", 0, DEV_RESET_N);
    check("program supply", 1, PROGRAM_SUPPLY_HI);
    check("core supply", 1, CORE_SUPPLY_6V);
    @(negedge REF_CLK);
    START = 0;
    for (t = 0; t < 60000 && q.size() != 0; t++)
      @(negedge REF_CLK);
    check("pending notes", 0, q.size());
    if (q.size() != 0)
      stop_test();
  endtask
  initial
  begin
    void'($urandom(17));
    repeat (20) @(negedge REF_CLK);
    RST = 0;
    job(0, 3);
    RST = 1;
    stuck = 1;
    repeat (20) @(negedge REF_CLK);
    RST = 0;
    job(1, 1);
    @(negedge REF_CLK);
    check("busy after fail", 0, BUSY);
    check("fail flag", 1, FAIL);
    check("done flag", 0, DONE);
    check("device released", 1, DEV_RESET_N);
    stop_test();
  end
endmodule
`default_nettype wire
